/* File: shared/cache_pkg.sv */
// Constants of the cache control block.
// Assumes a 32-bit Wishbone bus and one clock.
package cache_pkg;
    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0]  CACHE_CONTROL_OFFSET = 8'h00;
    localparam logic [31:0] CACHE_CONTROL_RESET  = 32'h0000_0007;
    localparam logic [31:0] CACHE_CONTROL_MASK   = 32'h0001_0337;
    localparam logic [31:0] UNMAPPED_READ_VALUE  = 32'h0000_0000;

    // ****************************************************************
    // Field positions of cache_control
    // ****************************************************************
    localparam int WAIT_LSB      = 0;
    localparam int WAIT_MSB      = 2;
    localparam int PREFETCH_LSB  = 4;
    localparam int PREFETCH_MSB  = 5;
    localparam int DSIZE_LSB     = 8;
    localparam int DSIZE_MSB     = 9;
    localparam int COHERENCY_BIT = 16;

    // ****************************************************************
    // Field encodings
    // ****************************************************************
    localparam logic [1:0] DSIZE_OFF     = 2'h0;
    localparam logic [1:0] DSIZE_ONE     = 2'h1;
    localparam logic [1:0] DSIZE_TWO     = 2'h2;
    localparam logic [1:0] DSIZE_FOUR    = 2'h3;
    localparam logic [2:0] LINES_NONE    = 3'h0;
    localparam logic [2:0] LINES_ONE     = 3'h1;
    localparam logic [2:0] LINES_TWO     = 3'h2;
    localparam logic [2:0] LINES_FOUR    = 3'h4;
    localparam int         PF_CACHEABLE_BIT = 0;
    localparam int         PF_UNCACHED_BIT  = 1;
    localparam logic [31:0] WORD_STRIDE  = 32'h0000_0004;

    typedef enum logic [1:0] {
        FETCH_IDLE,
        FETCH_FLASH,
        FETCH_PREFETCH
    } fetch_state_t;
endpackage

/* File: shared/line_store_if.sv */
// Links the fetch controller to the line store.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface line_store_if;
    logic [31:0] lookup_addr;   // Address being looked up
    logic        lookup_data;   // Lookup is a data access
    logic        hit;           // Lookup hits a valid line
    logic [31:0] hit_word;      // Word of the hitting line
    logic        fill_en;       // Write one line
    logic [31:0] fill_addr;
    logic [31:0] fill_word;
    logic        fill_data;     // Line goes to the data side
    logic        fill_lock;     // Instruction line is locked
    logic [2:0]  data_lines;    // Data lines in use, zero disables
    logic        inv_all;       // Invalidate every line
    logic        inv_unlocked;  // Invalidate data and unlocked instruction lines

    modport ctrl (output lookup_addr, lookup_data, fill_en, fill_addr, fill_word, fill_data,
                  fill_lock, data_lines, inv_all, inv_unlocked,
                  input hit, hit_word);
    modport store (input lookup_addr, lookup_data, fill_en, fill_addr, fill_word, fill_data,
                   fill_lock, data_lines, inv_all, inv_unlocked,
                   output hit, hit_word);
endinterface

/* File: rtl/wait_state_timer.sv */
// Counts flash wait states for one flash access.
// Assumes start is a one-cycle pulse and no new start before done.
`timescale 1ns/1ps
module wait_state_timer (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Control
    input  wire logic       start_i,
    input  wire logic [2:0] wait_count_i,
    output logic            done_o
);
    logic [2:0] remaining;
    logic       busy;
    logic [2:0] next_remaining;
    logic       next_busy;
    logic       next_done;

    // ****************************************************************
    // Countdown
    // ****************************************************************
    // Done rises wait_count plus two cycles after the start pulse
    always_comb begin
        next_remaining = remaining;
        next_busy      = busy;
        next_done      = 1'b0;
        if (start_i) begin
            next_remaining = wait_count_i;
            next_busy      = 1'b1;
        end else if (busy) begin
            if (remaining == 3'h0) begin
                next_busy = 1'b0;
                next_done = 1'b1;
            end else begin
                next_remaining = remaining - 3'h1;
            end
        end
    end

    // Registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            remaining <= 3'h0;
            busy      <= 1'b0;
            done_o    <= 1'b0;
        end else begin
            remaining <= next_remaining;
            busy      <= next_busy;
            done_o    <= next_done;
        end
    end
endmodule

/* File: rtl/cache_line_store.sv */
// Instruction and data lines of the prefetch cache, one word per line.
// Assumes one clock for lookup, fill and invalidate.
`timescale 1ns/1ps
module cache_line_store #(
    parameter int LINES = 4
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Controller side
    line_store_if.store ls
);
    logic [31:0] tag     [2*LINES];
    logic [31:0] word    [2*LINES];
    logic        valid   [2*LINES];
    logic        locked  [2*LINES];
    logic [1:0]  inst_victim;
    logic [1:0]  data_victim;
    logic [1:0]  next_inst_victim;
    logic [1:0]  next_data_victim;
    logic [2*LINES-1:0] match;

    // ****************************************************************
    // Lookup; low half instructions, high half data
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < 2 * LINES; g++) begin : g_match
            localparam bit IS_DATA = (g >= LINES);
            localparam logic [2:0] SLOT = 3'(g % LINES);
            assign match[g] = valid[g] && (tag[g] == ls.lookup_addr) && (ls.lookup_data == IS_DATA)
                              && (!IS_DATA || SLOT < ls.data_lines);
        end
    endgenerate

    // Hit mux
    always_comb begin
        ls.hit      = 1'b0;
        ls.hit_word = 32'h0000_0000;
        for (int i = 0; i < 2 * LINES; i++) begin
            if (match[i]) begin
                ls.hit      = 1'b1;
                ls.hit_word = word[i];
            end
        end
    end

    // Victims; data side wraps at the line count
    always_comb begin
        next_inst_victim = inst_victim;
        next_data_victim = data_victim;
        if (ls.fill_en && !ls.fill_data) begin
            next_inst_victim = inst_victim + 2'h1;
        end
        if (ls.fill_en && ls.fill_data) begin
            next_data_victim = ({1'b0, data_victim} + 3'h1 >= ls.data_lines) ? 2'h0 : data_victim + 2'h1;
        end
    end

    // Line arrays
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            inst_victim <= 2'h0;
            data_victim <= 2'h0;
            for (int i = 0; i < 2 * LINES; i++) begin
                valid[i]  <= 1'b0;
                locked[i] <= 1'b0;
                tag[i]    <= 32'h0000_0000;
                word[i]   <= 32'h0000_0000;
            end
        end else begin
            inst_victim <= next_inst_victim;
            data_victim <= next_data_victim;
            for (int i = 0; i < 2 * LINES; i++) begin
                if (ls.inv_all) begin
                    valid[i]  <= 1'b0;
                    locked[i] <= 1'b0;
                end else if (ls.inv_unlocked && (i >= LINES || !locked[i])) begin
                    valid[i] <= 1'b0;
                end
            end
            if (ls.fill_en && !ls.inv_all && !ls.inv_unlocked) begin
                if (!ls.fill_data && !locked[inst_victim]) begin
                    valid[inst_victim]  <= 1'b1;
                    locked[inst_victim] <= ls.fill_lock;
                    tag[inst_victim]    <= ls.fill_addr;
                    word[inst_victim]   <= ls.fill_word;
                end else if (ls.fill_data && ls.data_lines != 3'h0) begin
                    valid[LINES + data_victim] <= 1'b1;
                    tag[LINES + data_victim]   <= ls.fill_addr;
                    word[LINES + data_victim]  <= ls.fill_word;
                end
            end
        end
    end
endmodule

/* File: rtl/flash_prefetch_cache_control.sv */
// Prefetch cache control: register, fetch sequencing, wait states.
// Assumes a classic Wishbone master and flash data
// stable while flash_req_o is high.
//
// Design decisions made here: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
// Summary of operation
// - Coherency set: program cycle invalidates every line.
// - Coherency clear: program cycle invalidates data and unlocked instruction lines.
// - Data size field: 11 four lines, 10 two, 01 one, 00 data caching off.
// - Changing the data size field invalidates every line.
// - Prefetch field: 11 both regions, 10 non-cacheable, 01 cacheable, 00 off.
// - Wait field sets zero to seven flash wait states.
module flash_prefetch_cache_control
    import cache_pkg::*;
#(
    parameter int LINES = 4
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // Fetch port from the core
    input  wire logic        fetch_req_i,
    input  wire logic [31:0] fetch_addr_i,
    input  wire logic        fetch_data_i,
    input  wire logic        fetch_cacheable_i,
    input  wire logic        fetch_lock_i,
    output logic             fetch_ready_o,
    output logic [31:0]      fetch_word_o,
    // Program flash array
    output logic             flash_req_o,
    output logic [31:0]      flash_addr_o,
    input  wire logic [31:0] flash_word_i,
    input  wire logic        program_cycle_i
);
    import cache_pkg::*;

    // ****************************************************************
    // Declarations
    // ****************************************************************
    line_store_if ls ();

    logic [31:0]  cache_control;
    logic [31:0]  next_cache_control;
    logic [31:0]  next_wb_dat;
    logic         next_wb_ack;
    logic         size_changed;
    logic         bus_hit;
    logic [31:0]  lane_mask;

    fetch_state_t state;
    fetch_state_t next_state;
    logic         next_fetch_ready;
    logic [31:0]  next_fetch_word;
    logic         next_flash_req;
    logic [31:0]  next_flash_addr;
    logic         req_data;
    logic         req_cacheable;
    logic         req_lock;
    logic         next_req_data;
    logic         next_req_cacheable;
    logic         next_req_lock;
    logic [31:0]  pf_addr;
    logic [31:0]  pf_word;
    logic         pf_valid;
    logic [31:0]  next_pf_addr;
    logic [31:0]  next_pf_word;
    logic         next_pf_valid;
    logic         timer_start;
    logic         timer_done;
    logic         pf_allowed;
    logic         pf_hit;

    logic [2:0]   wait_states;
    logic [1:0]   prefetch_region_select;
    logic [1:0]   data_cache_line_count;
    logic         program_cycle_invalidate_all;

    // Field views of the control register
    assign wait_states                  = cache_control[WAIT_MSB:WAIT_LSB];
    assign prefetch_region_select       = cache_control[PREFETCH_MSB:PREFETCH_LSB];
    assign data_cache_line_count        = cache_control[DSIZE_MSB:DSIZE_LSB];
    assign program_cycle_invalidate_all = cache_control[COHERENCY_BIT];

    // ****************************************************************
    // Register bus
    // ****************************************************************
    // Byte lane mask
    always_comb begin
        lane_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    end

    // One-cycle answer; unmapped addresses ack and read zero
    always_comb begin
        bus_hit            = wb_cyc_i && wb_stb_i && !wb_ack_o;
        next_wb_ack        = bus_hit;
        next_wb_dat        = wb_dat_o;
        next_cache_control = cache_control;
        if (bus_hit) begin
            if (wb_adr_i == CACHE_CONTROL_OFFSET) begin
                next_wb_dat = cache_control & CACHE_CONTROL_MASK;
                if (wb_we_i) begin
                    // Unimplemented bits stay zero
                    next_cache_control = ((cache_control & ~lane_mask) | (wb_dat_i & lane_mask))
                                         & CACHE_CONTROL_MASK;
                end
            end else begin
                next_wb_dat = UNMAPPED_READ_VALUE;
            end
        end
        size_changed = next_cache_control[DSIZE_MSB:DSIZE_LSB] != data_cache_line_count;
    end

    // Bus registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cache_control <= CACHE_CONTROL_RESET;
            wb_dat_o      <= 32'h0000_0000;
            wb_ack_o      <= 1'b0;
        end else begin
            cache_control <= next_cache_control;
            wb_dat_o      <= next_wb_dat;
            wb_ack_o      <= next_wb_ack;
        end
    end

    // ****************************************************************
    // Line store controls
    // ****************************************************************
    // Data line count decode
    always_comb begin
        unique case (data_cache_line_count)
            DSIZE_OFF:  ls.data_lines = LINES_NONE;
            DSIZE_ONE:  ls.data_lines = LINES_ONE;
            DSIZE_TWO:  ls.data_lines = LINES_TWO;
            DSIZE_FOUR: ls.data_lines = LINES_FOUR;
        endcase
    end

    // Invalidation requests
    always_comb begin
        ls.inv_all      = size_changed || (program_cycle_i && program_cycle_invalidate_all);
        ls.inv_unlocked = program_cycle_i && !program_cycle_invalidate_all;
        ls.lookup_addr  = fetch_addr_i;
        ls.lookup_data  = fetch_data_i;
    end

    // Prefetch allowed for this miss's region
    always_comb begin
        pf_allowed = req_cacheable ? prefetch_region_select[PF_CACHEABLE_BIT]
                                   : prefetch_region_select[PF_UNCACHED_BIT];
        pf_hit     = pf_valid && (pf_addr == fetch_addr_i) && !fetch_data_i;
    end

    cache_line_store #(
        .LINES (LINES)
    ) u_store (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .ls    (ls.store)
    );

    wait_state_timer u_timer (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .start_i      (timer_start),
        .wait_count_i (wait_states),
        .done_o       (timer_done)
    );

    // ****************************************************************
    // Fetch sequencer
    // ****************************************************************
    // Misses, prefetch and fills
    always_comb begin
        next_state         = state;
        next_fetch_ready   = 1'b0;
        next_fetch_word    = fetch_word_o;
        next_flash_req     = flash_req_o;
        next_flash_addr    = flash_addr_o;
        next_req_data      = req_data;
        next_req_cacheable = req_cacheable;
        next_req_lock      = req_lock;
        next_pf_addr       = pf_addr;
        next_pf_word       = pf_word;
        next_pf_valid      = pf_valid;
        timer_start        = 1'b0;
        ls.fill_en         = 1'b0;
        ls.fill_addr       = flash_addr_o;
        ls.fill_word       = flash_word_i;
        ls.fill_data       = req_data;
        ls.fill_lock       = req_lock;
        unique case (state)
            FETCH_IDLE: begin
                if (fetch_req_i && !fetch_ready_o) begin
                    if (ls.hit && fetch_cacheable_i) begin
                        next_fetch_ready = 1'b1;
                        next_fetch_word  = ls.hit_word;
                    end else if (pf_hit) begin
                        next_fetch_ready = 1'b1;
                        next_fetch_word  = pf_word;
                        next_pf_valid    = 1'b0;
                    end else begin
                        // Miss: open a flash read, stall
                        next_state         = FETCH_FLASH;
                        next_flash_req     = 1'b1;
                        next_flash_addr    = fetch_addr_i;
                        next_req_data      = fetch_data_i;
                        next_req_cacheable = fetch_cacheable_i;
                        next_req_lock      = fetch_lock_i;
                        timer_start        = 1'b1;
                    end
                end
            end
            FETCH_FLASH: begin
                if (timer_done) begin
                    // Wait over: answer, and fill if cacheable
                    next_fetch_ready = 1'b1;
                    next_fetch_word  = flash_word_i;
                    ls.fill_en       = req_cacheable;
                    if (pf_allowed && !req_data) begin
                        next_state      = FETCH_PREFETCH;
                        next_flash_addr = flash_addr_o + WORD_STRIDE;
                        next_pf_valid   = 1'b0;
                        timer_start     = 1'b1;
                    end else begin
                        next_state     = FETCH_IDLE;
                        next_flash_req = 1'b0;
                    end
                end
            end
            FETCH_PREFETCH: begin
                if (timer_done) begin
                    next_state     = FETCH_IDLE;
                    next_flash_req = 1'b0;
                    next_pf_addr   = flash_addr_o;
                    next_pf_word   = flash_word_i;
                    next_pf_valid  = 1'b1;
                end
            end
        endcase
        if (ls.inv_all || ls.inv_unlocked) begin
            next_pf_valid = 1'b0;
        end
    end

    // Sequencer registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state         <= FETCH_IDLE;
            fetch_ready_o <= 1'b0;
            fetch_word_o  <= 32'h0000_0000;
            flash_req_o   <= 1'b0;
            flash_addr_o  <= 32'h0000_0000;
            req_data      <= 1'b0;
            req_cacheable <= 1'b0;
            req_lock      <= 1'b0;
            pf_addr       <= 32'h0000_0000;
            pf_word       <= 32'h0000_0000;
            pf_valid      <= 1'b0;
        end else begin
            state         <= next_state;
            fetch_ready_o <= next_fetch_ready;
            fetch_word_o  <= next_fetch_word;
            flash_req_o   <= next_flash_req;
            flash_addr_o  <= next_flash_addr;
            req_data      <= next_req_data;
            req_cacheable <= next_req_cacheable;
            req_lock      <= next_req_lock;
            pf_addr       <= next_pf_addr;
            pf_word       <= next_pf_word;
            pf_valid      <= next_pf_valid;
        end
    end
endmodule

/* File: bench/flash_model.sv */
// Behavioural program flash array facing the cache controller.
// Assumes the controller holds flash_addr_o through each wait period while flash_req_o is high.
`timescale 1ns/1ps
module flash_model #(
    parameter logic [31:0] SCRAMBLE = 32'hc3a5_0f96
) (
    // Clock
    input  wire logic        clk_i,
    // Flash read port
    input  wire logic        req_i,
    input  wire logic [31:0] addr_i,
    output logic [31:0]      word_o
);
    logic [31:0] idle = 32'h5555_aaaa;

    // Released data toggles so stale words never match
    always_ff @(posedge clk_i) begin
        idle <= ~idle;
    end

    // Word depends only on the address while a read is open
    assign word_o = req_i ? (addr_i ^ SCRAMBLE) : idle;
endmodule

/* File: bench/cache_checker.sv */
// Port checks for the flash prefetch cache control block.
// Assumes it is bound into flash_prefetch_cache_control.
`timescale 1ns/1ps
module cache_checker
    import cache_pkg::*;
#(
    parameter int LINES = 4
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Register bus
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [31:0] wb_dat_o,
    input  wire logic        wb_ack_o,
    // Fetch and flash
    input  wire logic        fetch_ready_o,
    input  wire logic [31:0] fetch_word_o,
    input  wire logic        flash_req_o
);
    logic [2:0] ws;
    logic [3:0] cnt;
    logic       pend;
    logic       req_q;

    // Wait field shadow and cycles since a flash read opened
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ws <= 3'h7;
            pend <= 1'b0;
            cnt <= 4'h0;
            req_q <= 1'b0;
        end else begin
            req_q <= flash_req_o;
            if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == 8'h00) ws <= wb_dat_i[2:0];
            if (flash_req_o && !req_q) begin
                pend <= 1'b1;
                cnt <= 4'h1;
            end else if (pend && fetch_ready_o) pend <= 1'b0;
            else if (pend) cnt <= cnt + 4'h1;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    ack_one_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
    ack_drop_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    unimpl_zero_a:
        assert property (wb_ack_o && !wb_we_i |-> (wb_dat_o & ~CACHE_CONTROL_MASK) == 32'h0) else $error("bits set");
    wait_read_a:
        assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h00 |-> wb_dat_o[2:0] == ws) else $error("wait field");
    wait_time_a:
        assert property (fetch_ready_o && pend |-> cnt == {1'b0, ws} + 4'h2) else $error("miss latency");
    miss_bound_a:
        assert property (pend |-> cnt <= {1'b0, ws} + 4'h2) else $error("miss overdue");
    ready_pulse_a: assert property (fetch_ready_o |=> !fetch_ready_o) else $error("ready too long");
    word_hold_a: assert property ($changed(fetch_word_o) |-> fetch_ready_o) else $error("word moved");

    cover property (fetch_ready_o && pend);
    cover property (fetch_ready_o && !flash_req_o);
    cover property (wb_ack_o && wb_we_i);
endmodule

bind flash_prefetch_cache_control cache_checker #(.LINES(LINES)) i_chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .fetch_ready_o(fetch_ready_o), .fetch_word_o(fetch_word_o), .flash_req_o(flash_req_o));

/* File: bench/tb.sv */
// Self-checking bench for the cache control block.
// Assumes the flash model and checker compile first.
`timescale 1ns/1ps
module tb;
    import cache_pkg::*;
    localparam logic [31:0] SCR = 32'hc3a5_0f96;
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic        req = 1'b0, is_data = 1'b0, cacheable = 1'b0, lock = 1'b0, prog = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0, faddr = 32'h0, r, rdat, word, fadr, fword;
    logic        ack, ready, flash_req;
    int          err_total = 0, check_count = 0, n, lines;
    bit          miss;

    // Clock of 25 ns
    always #12.5 clk_i = ~clk_i;

    flash_prefetch_cache_control i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .fetch_req_i(req),
        .fetch_addr_i(faddr), .fetch_data_i(is_data), .fetch_cacheable_i(cacheable), .fetch_lock_i(lock),
        .fetch_ready_o(ready), .fetch_word_o(word), .flash_req_o(flash_req), .flash_addr_o(fadr),
        .flash_word_i(fword), .program_cycle_i(prog));
    flash_model #(.SCRAMBLE(SCR)) i_flash (.clk_i(clk_i), .req_i(flash_req), .addr_i(fadr), .word_o(fword));

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic chk_word(input logic [31:0] got, exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // One classic Wishbone cycle, released after the ack edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v, output logic [31:0] d);
        int k;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= v;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (!(ack === 1'b1) && k < 16);
        if (ack !== 1'b1) err_total++;
        d = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    // Fetch held until ready; a rising flash request marks a miss
    task automatic fetch(input logic [31:0] a, input logic dt, c, l);
        logic prev;
        @(posedge clk_i);
        req <= 1'b1;
        faddr <= a;
        is_data <= dt;
        cacheable <= c;
        lock <= l;
        prev = flash_req;
        miss = 1'b0;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
            if (flash_req && !prev) miss = 1'b1;
            prev = flash_req;
        end while (!(ready === 1'b1) && n < 64);
        if (ready !== 1'b1) err_total++;
        chk_word(word, a ^ SCR);
        req <= 1'b0;
    endtask

    task automatic probe(input logic [31:0] a, input logic dt, c, l, input bit m);
        fetch(a, dt, c, l);
        chk_word(32'(miss), 32'(m));
    endtask

    task automatic program_pulse;
        @(posedge clk_i);
        prog <= 1'b1;
        @(posedge clk_i);
        prog <= 1'b0;
    endtask

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, 8'h00, 32'h0, r);
        chk_word(r, 32'h0000_0007);
        wb(1'b1, 8'h00, 32'hffff_ffff, r);
        wb(1'b0, 8'h00, 32'h0, r);
        chk_word(r, 32'h0001_0337);
        wb(1'b1, 8'h10, 32'h0000_0005, r);
        wb(1'b0, 8'h10, 32'h0, r);
        chk_word(r, 32'h0);
        $display("test registers done");
        for (int i = 0; i < 8; i++) begin
            wb(1'b1, 8'h00, 32'(i), r);
            fetch(32'h100 + 32'(4 * i), 1'b0, 1'b0, 1'b0);
            chk_word(32'(n), 32'(i + 4));
        end
        $display("test wait states done");
        wb(1'b1, 8'h00, 32'h0000_0101, r);
        probe(32'h2000, 1'b0, 1'b1, 1'b1, 1'b1);
        probe(32'h2010, 1'b0, 1'b1, 1'b0, 1'b1);
        probe(32'h3000, 1'b1, 1'b1, 1'b0, 1'b1);
        probe(32'h3000, 1'b1, 1'b1, 1'b0, 1'b0);
        program_pulse;
        probe(32'h2000, 1'b0, 1'b1, 1'b0, 1'b0);
        probe(32'h2010, 1'b0, 1'b1, 1'b0, 1'b1);
        probe(32'h3000, 1'b1, 1'b1, 1'b0, 1'b1);
        wb(1'b1, 8'h00, 32'h0001_0101, r);
        program_pulse;
        probe(32'h2000, 1'b0, 1'b1, 1'b0, 1'b1);
        probe(32'h2010, 1'b0, 1'b1, 1'b0, 1'b1);
        $display("test program cycle done");
        for (int s = 0; s < 4; s++) begin
            lines = (s == 3) ? 4 : s;
            wb(1'b1, 8'h00, 32'(s) << 8, r);
            for (int k = 0; k < 4; k++)
                if (k < lines || k == 0) fetch(32'h4000 + 32'(256 * s + 4 * k), 1'b1, 1'b1, 1'b0);
            probe(32'h4000 + 32'(256 * s), 1'b1, 1'b1, 1'b0, lines == 0);
        end
        wb(1'b1, 8'h00, 32'h0000_0300, r);
        probe(32'h4300, 1'b1, 1'b1, 1'b0, 1'b0);
        wb(1'b1, 8'h00, 32'h0000_0200, r);
        probe(32'h4300, 1'b1, 1'b1, 1'b0, 1'b1);
        $display("test data size done");
        for (int p = 0; p < 4; p++) begin
            wb(1'b1, 8'h00, 32'(p) << 4, r);
            for (int c = 0; c < 2; c++) begin
                fetch(32'h8000 + 32'(64 * p + 32 * c), 1'b0, c[0], 1'b0);
                probe(32'h8004 + 32'(64 * p + 32 * c), 1'b0, c[0], 1'b0, !(c[0] ? p[0] : p[1]));
            end
        end
        $display("test prefetch done");
        end_sim;
    end

    // Watchdog, far beyond the test length
    initial begin
        #500000;
        err_total++;
        end_sim;
    end
endmodule
